// File: src/qhp_pkg.sv
/*
 * Constants and types for the host bus port of the four-channel UART.
 * Assumes one clock at 100 MHz and channel logic on that same clock behind the port.
 */
// Operation
// R1 - Interface-select high strobes, low shared strobe
// R2 - Three address lines pick one register
// R3 - Eight-bit data bus, device drives reads
// R4 - Read strobe fall starts read, drive byte
// R5 - Write strobe rise stores bus byte
// R6 - Shared style: direction high read, low write
// R7 - Four chip selects enable channels A-D
// R8 - Shared style: channel A select qualifies all
// R9 - Shared style: B, C selects become address
// R10 - Shared style: read strobe, select D held high
// R11 - Channel bits zero to three pick A-D
// R12 - Data bus undriven outside reads
package qhp_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int QHP_DATA_W = 8;
   localparam int QHP_ADDR_W = 3;
   localparam int QHP_NCHAN = 4;
   localparam int QHP_CHAN_W = 2;

   // ************************************************************
   // Pin positions and codes
   // ************************************************************
   localparam int QHP_CS_A = 0;
   localparam int QHP_CS_B = 1;
   localparam int QHP_CS_C = 2;
   localparam logic QHP_SEL_STROBES = 1'h1;
   localparam logic QHP_DIR_READ = 1'h1;
   localparam logic [QHP_CHAN_W-1:0] QHP_CHAN_A = 2'h0;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      QHP_IDLE,
      QHP_RD_LOAD,
      QHP_RD_DRIVE,
      QHP_WR_HOLD
   } qhp_state_e;

   typedef struct packed {
      logic isel;
      logic rd_n;
      logic wr_n;
      logic [QHP_NCHAN-1:0] cs_n;
      logic [QHP_ADDR_W-1:0] addr;
      logic [QHP_DATA_W-1:0] data;
   } qhp_pins_s;

   typedef struct packed {
      qhp_pins_s sy1;
      qhp_pins_s sy2;
      logic prv_rd_n;
      logic prv_wr_n;
      logic prv_csa_n;
      qhp_state_e fsm;
      logic [QHP_CHAN_W-1:0] chan;
      logic [QHP_ADDR_W-1:0] addr;
      logic [QHP_DATA_W-1:0] wdata;
      logic [QHP_DATA_W-1:0] dout;
      logic oe;
      logic rd_req;
      logic wr_req;
   } qhp_state_s;

endpackage

// File: src/qhp_host_port.sv
/*
 * Host bus port of the four-channel UART: samples the asynchronous host pins,
 * turns strobes into one-cycle register requests and drives read data back.
 * Both bus styles share one sequencer; the mode pin only changes how the pins decode.
 * Assumes the channel logic presents the read byte one cycle after a read request,
 * that the host holds address and data until its strobe or select lifts,
 * and that the mode pin is static while a transfer is open.
 * Every host pin passes two flip-flops, so the port answers three cycles after a pin moves.
 */
`timescale 1ns/100ps
module qhp_host_port (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RSTN,
   // Host bus pins
   input wire logic I_IF_SEL,
   input wire logic I_READ_STROBE_N,
   input wire logic I_WRITE_STROBE_N,
   input wire logic I_CHAN_A_SELECT_N,
   input wire logic I_CHAN_B_SELECT_N,
   input wire logic I_CHAN_C_SELECT_N,
   input wire logic I_CHAN_D_SELECT_N,
   input wire logic [qhp_pkg::QHP_ADDR_W-1:0] I_REG_ADDR,
   input wire logic [qhp_pkg::QHP_DATA_W-1:0] I_DATA,
   output logic [qhp_pkg::QHP_DATA_W-1:0] O_DATA,
   output logic O_DATA_OE,
   // Channel side
   output logic O_RD_REQ,
   output logic O_WR_REQ,
   output logic [qhp_pkg::QHP_CHAN_W-1:0] O_CHAN,
   output logic [qhp_pkg::QHP_ADDR_W-1:0] O_REG_ADDR,
   output logic [qhp_pkg::QHP_DATA_W-1:0] O_WR_DATA,
   input wire logic [qhp_pkg::QHP_DATA_W-1:0] I_RD_DATA
);

   // ************************************************************
   // Channel decode
   // ************************************************************
   // With several selects low at once the lowest channel wins; hosts should never do that
   function automatic logic [qhp_pkg::QHP_CHAN_W-1:0] chan_of(input logic strobes,
                                                              input logic [qhp_pkg::QHP_NCHAN-1:0] cs_n);
      logic [qhp_pkg::QHP_CHAN_W-1:0] c;
      c = qhp_pkg::QHP_CHAN_A;
      if (strobes) begin
         for (int i = qhp_pkg::QHP_NCHAN - 1; i >= 0; i--) begin
            if (!cs_n[i]) begin
               c = qhp_pkg::QHP_CHAN_W'(i); // [R7]
            end
         end
      end else begin
         c = {cs_n[qhp_pkg::QHP_CS_C], cs_n[qhp_pkg::QHP_CS_B]}; // [R9] [R11]
      end
      return c;
   endfunction

   // ************************************************************
   // Strobe helpers
   // ************************************************************
   // A transfer starts only on a high-to-low step of a synced pin, never on a low level,
   // so a strobe left low across a mode change cannot start a second transfer
   function automatic logic fell_of(input logic was_n,
                                    input logic now_n);
      logic f;
      f = was_n & ~now_n;
      return f;
   endfunction

   // Direction line of the shared style; high asks for a read
   function automatic logic is_read(input logic dir);
      logic r;
      r = (dir == qhp_pkg::QHP_DIR_READ);
      return r;
   endfunction

   // End of a transfer: the strobe lifts in strobe style, the one select lifts otherwise
   function automatic logic lifted_of(input logic strobes,
                                      input logic strobe_n,
                                      input logic csa_n);
      logic l;
      if (strobes) begin
         l = strobe_n;
      end else begin
         l = csa_n;
      end
      return l;
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   // Whole port state in one register: pin stages, edge history, sequencer and outputs
   qhp_pkg::qhp_state_s st_r;
   qhp_pkg::qhp_state_s st_nxt;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic strobes;
      logic sel;
      logic rd_go;
      logic wr_go;
      logic rd_end;
      logic wr_end;
      qhp_pkg::qhp_pins_s p;
      strobes = 1'h0;
      sel = 1'h0;
      rd_go = 1'h0;
      wr_go = 1'h0;
      rd_end = 1'h0;
      wr_end = 1'h0;
      p = st_r.sy2;
      st_nxt = st_r;

      // Two stages before any logic looks at a pin
      st_nxt.sy1.isel = I_IF_SEL;
      st_nxt.sy1.rd_n = I_READ_STROBE_N;
      st_nxt.sy1.wr_n = I_WRITE_STROBE_N;
      st_nxt.sy1.cs_n = {I_CHAN_D_SELECT_N, I_CHAN_C_SELECT_N, I_CHAN_B_SELECT_N, I_CHAN_A_SELECT_N};
      st_nxt.sy1.addr = I_REG_ADDR;
      st_nxt.sy1.data = I_DATA;
      st_nxt.sy2 = st_r.sy1;

      // Previous synced levels for the edge finders
      st_nxt.prv_rd_n = p.rd_n;
      st_nxt.prv_wr_n = p.wr_n;
      st_nxt.prv_csa_n = p.cs_n[qhp_pkg::QHP_CS_A];

      // Requests are single-cycle pulses
      st_nxt.rd_req = 1'h0;
      st_nxt.wr_req = 1'h0;

      // Style decode
      strobes = (p.isel == qhp_pkg::QHP_SEL_STROBES); // [R1]
      if (strobes) begin
         sel = ~&p.cs_n; // [R7]
         rd_go = fell_of(st_r.prv_rd_n, p.rd_n) & sel; // [R4]
         wr_go = fell_of(st_r.prv_wr_n, p.wr_n) & sel; // [R5]
      end else begin
         // Read strobe and select D are not looked at in this style [R10]
         sel = fell_of(st_r.prv_csa_n, p.cs_n[qhp_pkg::QHP_CS_A]); // [R8]
         rd_go = sel & is_read(p.wr_n); // [R6]
         wr_go = sel & ~is_read(p.wr_n); // [R6]
      end
      rd_end = lifted_of(strobes, p.rd_n, p.cs_n[qhp_pkg::QHP_CS_A]);
      wr_end = lifted_of(strobes, p.wr_n, p.cs_n[qhp_pkg::QHP_CS_A]);

      // Transaction sequencer
      unique case (st_r.fsm)
         qhp_pkg::QHP_IDLE: begin
            // Bus released whenever no read is open
            st_nxt.oe = 1'h0; // [R12]
            if (rd_go) begin
               st_nxt.rd_req = 1'h1; // [R4]
               st_nxt.chan = chan_of(strobes, p.cs_n);
               st_nxt.addr = p.addr; // [R2]
               st_nxt.fsm = qhp_pkg::QHP_RD_LOAD;
            end else if (wr_go) begin
               // Channel is caught at the start: selects may lift with the strobe
               st_nxt.chan = chan_of(strobes, p.cs_n);
               st_nxt.fsm = qhp_pkg::QHP_WR_HOLD;
            end
         end

         qhp_pkg::QHP_RD_LOAD: begin
            // Channel byte is valid one cycle after the request; a strobe already lifted cancels the drive
            st_nxt.dout = I_RD_DATA; // [R3]
            st_nxt.oe = ~rd_end; // [R3]
            if (rd_end) begin
               st_nxt.fsm = qhp_pkg::QHP_IDLE;
            end else begin
               st_nxt.fsm = qhp_pkg::QHP_RD_DRIVE;
            end
         end

         qhp_pkg::QHP_RD_DRIVE: begin
            // Byte stands on the bus until the strobe or select lifts
            if (rd_end) begin
               st_nxt.oe = 1'h0; // [R12]
               st_nxt.fsm = qhp_pkg::QHP_IDLE;
            end
         end

         qhp_pkg::QHP_WR_HOLD: begin
            if (wr_end) begin
               // Byte and address taken as the strobe or select lifts; host holds them to then
               st_nxt.wr_req = 1'h1; // [R5]
               st_nxt.addr = p.addr; // [R2]
               st_nxt.wdata = p.data; // [R3]
               st_nxt.fsm = qhp_pkg::QHP_IDLE;
            end
         end
      endcase
   end

   // ************************************************************
   // State register
   // ************************************************************
   // Pins reset low so no false falling edge is seen at release
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Bus side
   assign O_DATA = st_r.dout;
   assign O_DATA_OE = st_r.oe; // [R12]

   // Channel side
   assign O_RD_REQ = st_r.rd_req;
   assign O_WR_REQ = st_r.wr_req;
   assign O_CHAN = st_r.chan;
   assign O_REG_ADDR = st_r.addr;
   assign O_WR_DATA = st_r.wdata;

endmodule // qhp_host_port

// File: testbench/qhp_chan_model.sv
/* Channel registers behind the port. Assumes reads are taken a cycle after the request. */
`timescale 1ns/100ps
module qhp_chan_model (
   input wire logic i_clk,
   input wire logic i_wr_req,
   input wire logic [1:0] i_chan,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   logic [7:0] mem_r [32];
   // Read is combinational so the byte is ready when the port samples it
   assign o_rdata = mem_r[{i_chan, i_addr}];
   always_ff @(posedge i_clk) begin
      if (i_wr_req) begin
         mem_r[{i_chan, i_addr}] <= i_wdata;
      end
   end
endmodule // qhp_chan_model

// File: testbench/qhp_chk.sv
/* Pin checker of the host port. Assumes the bind at the foot. */
`timescale 1ns/100ps
module qhp_chk (
   input wire logic I_CLK, I_RSTN, I_IF_SEL, I_READ_STROBE_N,
   input wire logic I_CHAN_A_SELECT_N, I_CHAN_B_SELECT_N, I_CHAN_C_SELECT_N, I_CHAN_D_SELECT_N,
   input wire logic [7:0] I_RD_DATA, O_DATA,
   input wire logic O_DATA_OE, O_RD_REQ, O_WR_REQ
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);
   req_excl_a: assert property (!(O_RD_REQ && O_WR_REQ)) else $error("both requests");
   rd_pulse_a: assert property (O_RD_REQ |=> !O_RD_REQ) else $error("long read");
   wr_pulse_a: assert property (O_WR_REQ |=> !O_WR_REQ) else $error("long write");
   oe_cause_a: assert property ($rose(O_DATA_OE) |-> $past(O_RD_REQ)) else $error("bad drive");
   rd_byte_a: assert property ($rose(O_DATA_OE) |-> O_DATA == $past(I_RD_DATA)) else $error("bad byte");
   oe_end_a: assert property (
      (I_IF_SEL && I_READ_STROBE_N) [*5] |-> !O_DATA_OE) else $error("late release");
   no_sel_a: assert property (
      (I_IF_SEL && I_CHAN_A_SELECT_N && I_CHAN_B_SELECT_N && I_CHAN_C_SELECT_N && I_CHAN_D_SELECT_N) [*5]
      |-> !(O_RD_REQ || O_WR_REQ)) else $error("unselected");
   sh_idle_a: assert property (
      (!I_IF_SEL && I_CHAN_A_SELECT_N) [*5] |-> !O_RD_REQ) else $error("no select");
   cover property (O_RD_REQ && !I_IF_SEL);
   cover property (O_WR_REQ && I_IF_SEL);
   cover property ($fell(O_DATA_OE));
endmodule // qhp_chk
bind qhp_host_port qhp_chk i_chk (.*);

// File: testbench/testbench.sv
/* Host on the port pins with a channel model behind. Assumes nothing else drives the bus. */
`timescale 1ns/100ps
module testbench;
   logic I_CLK = 0, I_RSTN = 0, I_IF_SEL = 1, I_READ_STROBE_N = 1, I_WRITE_STROBE_N = 1;
   logic I_CHAN_A_SELECT_N = 1, I_CHAN_B_SELECT_N = 1, I_CHAN_C_SELECT_N = 1, I_CHAN_D_SELECT_N = 1;
   logic O_DATA_OE, O_RD_REQ, O_WR_REQ;
   logic [1:0] O_CHAN;
   logic [2:0] I_REG_ADDR = 3'h0, O_REG_ADDR;
   logic [7:0] I_DATA, O_DATA, O_WR_DATA, I_RD_DATA, host_d = 8'h00;
   int bad_count = 0, checks_done = 0;
   // Wire level: device byte while it drives, else the host's
   assign I_DATA = O_DATA_OE ? O_DATA : host_d;
   qhp_host_port i_dut (.*);
   qhp_chan_model i_chan (.i_clk(I_CLK), .i_wr_req(O_WR_REQ), .i_chan(O_CHAN), .i_addr(O_REG_ADDR),
      .i_wdata(O_WR_DATA), .o_rdata(I_RD_DATA));
   initial forever #5 I_CLK = ~I_CLK;
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Style sel; st picks the strobe pins; exp[8] set when the device must drive exp[7:0]
   task automatic bus(input logic sel, st, rd, input logic [1:0] ch, input logic [2:0] a,
      input logic [7:0] d, input logic [3:0] cs, input logic [8:0] exp);
      I_IF_SEL <= sel;
      repeat (4) @(posedge I_CLK);
      I_REG_ADDR <= a;
      host_d <= d;
      if (!st) begin
         {I_CHAN_C_SELECT_N, I_CHAN_B_SELECT_N} <= ch;
         I_WRITE_STROBE_N <= rd;
      end
      @(posedge I_CLK);
      if (st) begin
         {I_CHAN_D_SELECT_N, I_CHAN_C_SELECT_N, I_CHAN_B_SELECT_N, I_CHAN_A_SELECT_N} <= cs;
         I_READ_STROBE_N <= !rd;
         I_WRITE_STROBE_N <= rd;
      end else begin
         I_CHAN_A_SELECT_N <= 0;
      end
      repeat (6) @(posedge I_CLK);
      @(negedge I_CLK);
      check({7'h0, O_DATA_OE}, {7'h0, exp[8]});
      if (exp[8]) check(O_DATA, exp[7:0]);
      @(posedge I_CLK);
      {I_CHAN_D_SELECT_N, I_CHAN_C_SELECT_N, I_CHAN_B_SELECT_N, I_CHAN_A_SELECT_N} <= 4'hf;
      I_READ_STROBE_N <= 1;
      I_WRITE_STROBE_N <= 1;
      // Data held past the rising strobe, then released
      repeat (5) @(posedge I_CLK);
      host_d <= ~d;
      @(negedge I_CLK);
      check({7'h0, O_DATA_OE}, 8'h00);
      @(posedge I_CLK);
   endtask
   task automatic t_strobe_wr_shared_rd;
      for (int c = 0; c < 4; c++) begin
         for (int a = 0; a < 8; a += 7) begin
            bus(1, 1, 0, 2'h0, a[2:0], {c[1:0], a[2:0], 3'h5}, ~(4'h1 << c), 9'h000);
            bus(0, 0, 1, c[1:0], a[2:0], 8'h00, 4'hf, {1'b1, c[1:0], a[2:0], 3'h5});
         end
      end
   endtask
   task automatic t_shared_wr_strobe_rd;
      for (int c = 0; c < 4; c++) begin
         for (int a = 0; a < 8; a += 7) begin
            bus(0, 0, 0, c[1:0], a[2:0], ~{c[1:0], a[2:0], 3'h5}, 4'hf, 9'h000);
            bus(1, 1, 1, 2'h0, a[2:0], 8'h00, ~(4'h1 << c), {1'b1, ~{c[1:0], a[2:0], 3'h5}});
         end
      end
   endtask
   task automatic t_refused;
      bus(1, 1, 0, 2'h0, 3'h0, 8'h3c, 4'hf, 9'h000);
      bus(0, 1, 1, 2'h0, 3'h0, 8'h00, 4'h7, 9'h000);
      bus(1, 1, 1, 2'h0, 3'h0, 8'h00, 4'he, 9'h1fa);
   endtask
   task automatic stop_test;
      if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge I_CLK);
      bad_count++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge I_CLK);
      I_RSTN <= 1;
      repeat (4) @(posedge I_CLK);
      t_strobe_wr_shared_rd();
      t_shared_wr_strobe_rd();
      t_refused();
      stop_test();
   end
endmodule // testbench
